/* cic_decimator.sv */
/*
  third order cic decimator from the modulator bit stream.
  assumes i_mod_valid is a one-cycle enable at the oversampled rate.
*/
`timescale 1ns/1ps
module cic_decimator import recpath_pkg::*; (
  input wire logic i_mclk,      // system clock
  input wire logic i_rstn,      // async reset, low
  input wire logic i_enable,    // converter enable
  input osr_t i_osr,            // decimation ratio
  input wire logic i_mod_bit,   // modulator bit
  input wire logic i_mod_valid, // bit strobe
  sample_if.src o_bus           // decimated words
);
  logic signed [25:0] int1_ff, int2_ff, int3_ff, dly1_ff, dly2_ff, dly3_ff;
  logic signed [25:0] step, c1, c2, c3;
  logic signed [26:0] scaled;
  logic [6:0] cnt_ff;
  logic last;
  // bit one means plus full scale, zero means minus
  assign step = i_mod_bit ? 26'sh0000001 : 26'sh3ffffff;
  assign last = i_mod_valid && (cnt_ff == ((i_osr == OSR_128) ? `OSR_HIGH_LAST : `OSR_LOW_LAST));
  assign c1 = int3_ff - dly1_ff;
  assign c2 = c1 - dly2_ff;
  assign c3 = c2 - dly3_ff;
  // gain is ratio cubed; shift both ratios to the same full scale
  assign scaled = (i_osr == OSR_128) ? {c3[25], c3} <<< `OSR_HIGH_SHIFT
                                     : {c3[25], c3} <<< `OSR_LOW_SHIFT;
  ////////////////////////////////////////////////////////////////////
  // integrators on bit stream
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn || !i_enable) begin
      int1_ff <= '0;
      int2_ff <= '0;
      int3_ff <= '0;
    end else if (i_mod_valid) begin
      int1_ff <= int1_ff + step;
      int2_ff <= int2_ff + int1_ff;
      int3_ff <= int3_ff + int2_ff;
    end
  end
  // ratio counter; wraps modulo the selected ratio
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn || !i_enable) cnt_ff <= '0;
    else if (last) cnt_ff <= '0;
    else if (i_mod_valid) cnt_ff <= cnt_ff + 7'h01;
  end
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn || !i_enable) begin
      dly1_ff <= '0;
      dly2_ff <= '0;
      dly3_ff <= '0;
      o_bus.data <= '0;
      o_bus.valid <= 1'b0;
    end else begin
      o_bus.valid <= last;
      if (last) begin
        dly1_ff <= int3_ff;
        dly2_ff <= c1;
        dly3_ff <= c2;
        o_bus.data <= sat24(scaled);
      end
    end
  end
endmodule // cic_decimator

/* record_path_adc_filter_control.sv */
/*
  record path control: register file, analog switch and gain decode,
  and the adc digital chain (decimator, smoother, high-pass, polarity).
  assumes a host write/read port synchronous to i_mclk and a modulator
  bit stream with a one-cycle strobe per bit.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - negative mic reaches amp inverting input only while its routing bit is set
// - aux routing bit mixes aux into the negative mic amp path
// - amp enable from power bit two; six-bit gain code from amp gain register
// - level loop enabled: loop gain replaces programmed amp gain
// - amp mute bit set disconnects amp output from boost mixer
// - boost stage powered only while boost enable bit is high
// - aux boost code zero disconnects; other codes connect with gain
// - amp path boost bit picks 0 dB or +20 dB
// - positive mic boost code zero disconnects; other codes connect
// - bias output enabled by power bit four
// - bias voltage from mode bit plus two-bit level field
// - 24-bit two's complement samples throughout the chain
// - decimator turns the modulator bit stream into sample-rate words
// - converter enable gates chain; polarity bit inverts samples
// - oversample bit picks ratio 64 or 128
// - high-pass applied only while its enable bit is high
// - audio mode first order near 3.7 Hz; application mode second order
// - application cut-off from code; rate pairs share cut-off table
// - cut-off ratio to sample rate is fixed per code
// - positive routing bit ties amp plus input to reference or mic
module record_path_adc_filter_control import recpath_pkg::*; (
  input wire logic i_mclk,                 // 100 MHz clock
  input wire logic i_rstn,                 // async reset, low
  input wire logic i_reg_wr,               // register write strobe
  input wire logic i_reg_rd,               // register read strobe
  input wire logic [6:0] i_reg_addr,       // register address
  input wire logic [8:0] i_reg_wdata,      // write data
  output logic [8:0] o_reg_rdata,          // read data
  output logic o_reg_rvalid,               // read data valid
  input wire logic [5:0] i_level_loop_gain, // gain from level loop
  input wire logic i_mod_bit,              // modulator bit
  input wire logic i_mod_valid,            // modulator bit strobe
  output logic o_neg_mic_to_amp,           // neg mic switch
  output logic o_pos_mic_to_amp,           // pos mic switch
  output logic o_aux_to_amp,               // aux into amp
  output logic o_input_amp_enable,         // amp power
  output logic [5:0] o_input_amp_gain_code, // applied amp gain
  output logic o_input_amp_zero_cross,     // zero-cross update
  output logic o_amp_to_mixer,             // amp to boost mixer
  output logic o_boost_enable,             // boost power
  output logic o_aux_boost_connect,        // aux to mixer
  output logic [2:0] o_aux_boost_gain,     // aux boost code
  output logic o_amp_path_boost,           // +20 dB select
  output logic o_pos_mic_boost_connect,    // pos mic to mixer
  output logic [2:0] o_pos_mic_boost_gain, // pos mic boost code
  output logic o_bias_output_enable,       // bias pin enable
  output logic [2:0] o_bias_select,        // {mode, level}
  output sample_t o_sample,                // sample to serializer
  output logic o_sample_valid              // sample strobe
);
  ////////////////////////////////////////////////////////////////////
  // register table lookups
  function automatic logic [6:0] reg_addr(input int i);
    case (i)
      0: return `ADDR_POWER_MANAGE_ONE;
      1: return `ADDR_POWER_MANAGE_TWO;
      2: return `ADDR_SAMPLE_RATE_SELECT;
      3: return `ADDR_ADC_FILTER_CONTROL;
      4: return `ADDR_LEVEL_LOOP_GAIN_LIMITS;
      5: return `ADDR_INPUT_ROUTING_CONTROL;
      6: return `ADDR_INPUT_AMP_GAIN;
      7: return `ADDR_BOOST_MIXER_CONTROL;
      default: return `ADDR_BIAS_MODE_CONTROL;
    endcase
  endfunction

  function automatic reg_word_t reg_mask(input int i);
    case (i)
      0: return `MASK_POWER_MANAGE_ONE;
      1: return `MASK_POWER_MANAGE_TWO;
      2: return `MASK_SAMPLE_RATE_SELECT;
      3: return `MASK_ADC_FILTER_CONTROL;
      4: return `MASK_LEVEL_LOOP_GAIN_LIMITS;
      5: return `MASK_INPUT_ROUTING_CONTROL;
      6: return `MASK_INPUT_AMP_GAIN;
      7: return `MASK_BOOST_MIXER_CONTROL;
      default: return `MASK_BIAS_MODE_CONTROL;
    endcase
  endfunction

  function automatic reg_word_t reg_reset(input int i);
    if (i == 4) return `RST_LEVEL_LOOP_GAIN_LIMITS;
    return `RST_DEFAULT;
  endfunction

  // first-order coefficient for a fixed 3.7 Hz corner per rate
  function automatic logic [15:0] audio_coef(input logic [2:0] rate);
    case (rate)
      `RATE_48K: return `AUDIO_COEF_48K;
      `RATE_32K: return `AUDIO_COEF_32K;
      `RATE_24K: return `AUDIO_COEF_24K;
      `RATE_16K: return `AUDIO_COEF_16K;
      `RATE_12K: return `AUDIO_COEF_12K;
      default: return `AUDIO_COEF_8K;
    endcase
  endfunction

  // corner scales with the rate, so the coefficient needs only the code
  function automatic logic [15:0] app_coef(input logic [2:0] code);
    case (code)
      3'h0: return `APP_COEF_0;
      3'h1: return `APP_COEF_1;
      3'h2: return `APP_COEF_2;
      3'h3: return `APP_COEF_3;
      3'h4: return `APP_COEF_4;
      3'h5: return `APP_COEF_5;
      3'h6: return `APP_COEF_6;
      default: return `APP_COEF_7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // register file
  reg_word_t regs_ff [`NUM_REGS];
  reg_word_t nxt_rdata;

  for (genvar g = 0; g < `NUM_REGS; g++) begin : g_reg
    always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) regs_ff[g] <= reg_reset(g);
      else if (i_reg_wr && i_reg_addr == reg_addr(g)) regs_ff[g] <= i_reg_wdata & reg_mask(g);
    end
  end

  always_comb begin
    nxt_rdata = '0;
    for (int i = 0; i < `NUM_REGS; i++) begin
      if (i_reg_addr == reg_addr(i)) nxt_rdata = regs_ff[i];
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= '0;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) o_reg_rdata <= nxt_rdata;
    end
  end

  // field views
  reg_word_t pm1, pm2, srate, adcctl, lvl, route, again, boost, bias;
  assign pm1 = regs_ff[0];
  assign pm2 = regs_ff[1];
  assign srate = regs_ff[2];
  assign adcctl = regs_ff[3];
  assign lvl = regs_ff[4];
  assign route = regs_ff[5];
  assign again = regs_ff[6];
  assign boost = regs_ff[7];
  assign bias = regs_ff[8];

  ////////////////////////////////////////////////////////////////////
  // analog path switches and gains, registered so pins never glitch
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_neg_mic_to_amp <= 1'b0;
      o_pos_mic_to_amp <= 1'b0;
      o_aux_to_amp <= 1'b0;
      o_input_amp_enable <= 1'b0;
      o_input_amp_gain_code <= '0;
      o_input_amp_zero_cross <= 1'b0;
    end else begin
      o_neg_mic_to_amp <= route[`BIT_NEG_MIC_TO_AMP];
      // plus input to mic or reference
      // host keeps this low for single-ended negative mic
      o_pos_mic_to_amp <= route[`BIT_POS_MIC_TO_AMP];
      o_aux_to_amp <= route[`BIT_AUX_TO_AMP];
      o_input_amp_enable <= pm2[`BIT_INPUT_AMP_ENABLE];
      o_input_amp_gain_code <= lvl[`BIT_LEVEL_LOOP_ENABLE] ? i_level_loop_gain : again[5:0];
      o_input_amp_zero_cross <= again[`BIT_INPUT_AMP_ZERO_CROSS];
    end
  end

  // boost mixer and bias
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_amp_to_mixer <= 1'b0;
      o_boost_enable <= 1'b0;
      o_aux_boost_connect <= 1'b0;
      o_aux_boost_gain <= '0;
      o_amp_path_boost <= 1'b0;
      o_pos_mic_boost_connect <= 1'b0;
      o_pos_mic_boost_gain <= '0;
      o_bias_output_enable <= 1'b0;
      o_bias_select <= '0;
    end else begin
      o_amp_to_mixer <= ~again[`BIT_INPUT_AMP_MUTE];
      o_boost_enable <= pm2[`BIT_BOOST_ENABLE];
      o_aux_boost_connect <= |boost[2:0];
      o_aux_boost_gain <= boost[2:0];
      o_amp_path_boost <= boost[`BIT_AMP_PATH_BOOST];
      // pos mic boost connect and gain
      o_pos_mic_boost_connect <= |boost[6:4];
      o_pos_mic_boost_gain <= boost[6:4];
      o_bias_output_enable <= pm1[`BIT_BIAS_OUTPUT_ENABLE];
      // bias code from mode and level
      o_bias_select <= {bias[`BIT_BIAS_MODE_SELECT], route[8:7]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // adc chain controls
  logic conv_en, inv, hp_en, hp_app;
  osr_t osr;
  assign conv_en = pm2[`BIT_CONVERTER_ENABLE];
  assign inv = adcctl[`BIT_CONVERTER_POLARITY];
  assign hp_en = adcctl[`BIT_HIGHPASS_ENABLE];
  assign hp_app = adcctl[`BIT_HIGHPASS_MODE];
  assign osr = adcctl[`BIT_OVERSAMPLE_SELECT] ? OSR_128 : OSR_64;

  sample_if dec_bus ();

  cic_decimator u_dec (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_enable(conv_en),
    .i_osr(osr),
    .i_mod_bit(i_mod_bit),
    .i_mod_valid(i_mod_valid),
    .o_bus(dec_bus)
  );

  // smoother after the decimator, two-tap average
  sample_t prev_ff, smooth_ff;
  logic smooth_vld_ff;
  logic signed [24:0] pair_sum;
  assign pair_sum = {dec_bus.data[23], dec_bus.data} + {prev_ff[23], prev_ff};

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn || !conv_en) begin
      prev_ff <= '0;
      smooth_ff <= '0;
      smooth_vld_ff <= 1'b0;
    end else begin
      smooth_vld_ff <= dec_bus.valid;
      if (dec_bus.valid) begin
        prev_ff <= dec_bus.data;
        smooth_ff <= pair_sum[24:1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // high-pass: y = x - x1 + a*y1, a in unsigned q16
  logic signed [25:0] xa_ff, ya_ff, xb_ff, yb_ff;
  logic signed [25:0] hp_in, y_a, y_b, filt;
  logic signed [17:0] coef;
  logic signed [43:0] prod_a, prod_b;
  logic signed [26:0] polv;

  assign hp_in = {{2{smooth_ff[23]}}, smooth_ff};
  // audio corner fixed, application corner selectable
  // same ratio to rate per code
  assign coef = hp_app ? $signed({2'b00, app_coef(adcctl[6:4])})
                       : $signed({2'b00, audio_coef(srate[3:1])});
  assign prod_a = ya_ff * coef;
  assign prod_b = yb_ff * coef;
  assign y_a = hp_in - xa_ff + $signed(prod_a[41:16]);
  // second section only in application mode
  assign y_b = y_a - xb_ff + $signed(prod_b[41:16]);

  assign filt = !hp_en ? hp_in : (hp_app ? y_b : y_a);
  // polarity inversion, widened so negating full scale cannot wrap
  assign polv = inv ? -{filt[25], filt} : {filt[25], filt};

  // filter state; cleared while bypassed so a re-enable starts clean
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn || !conv_en || !hp_en) begin
      xa_ff <= '0;
      ya_ff <= '0;
      xb_ff <= '0;
      yb_ff <= '0;
    end else if (smooth_vld_ff) begin
      xa_ff <= hp_in;
      ya_ff <= y_a;
      xb_ff <= hp_app ? y_a : 26'sh0000000;
      yb_ff <= hp_app ? y_b : 26'sh0000000;
    end
  end

  // last stage hands words to the serializer
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn || !conv_en) begin
      o_sample <= '0;
      o_sample_valid <= 1'b0;
    end else begin
      o_sample_valid <= smooth_vld_ff;
      if (smooth_vld_ff) o_sample <= sat24(polv);
    end
  end
endmodule // record_path_adc_filter_control

/* recpath_chk.sv */
/*
  port assertions for the record path top.
  assumes recpath_pkg and the defines header compile first.
*/
`timescale 1ns/1ps
`include "recpath_defines.svh"
module recpath_chk import recpath_pkg::*; (
  input wire logic i_mclk, // clock
  input wire logic i_rstn, // reset, low
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [6:0] i_reg_addr, // address
  input wire logic [8:0] i_reg_wdata, // write data
  input wire logic [8:0] o_reg_rdata, // read data
  input wire logic o_reg_rvalid, // read valid
  input wire logic [5:0] i_level_loop_gain, // loop gain
  input wire logic o_neg_mic_to_amp, // neg mic switch
  input wire logic [5:0] o_input_amp_gain_code, // applied gain
  input wire logic o_amp_to_mixer, // amp to mixer
  input wire logic o_boost_enable, // boost power
  input wire logic o_aux_boost_connect, // aux to mixer
  input wire logic [2:0] o_aux_boost_gain, // aux code
  input wire logic o_pos_mic_boost_connect, // pos mic to mixer
  input wire logic [2:0] o_pos_mic_boost_gain, // pos code
  input wire logic [2:0] o_bias_select, // bias code
  input wire sample_t o_sample, // output word
  input wire logic o_sample_valid // word strobe
);
  logic lvl_ff;
  logic mute_ff;
  logic adc_ff;
  logic mapped;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  assign mapped = i_reg_addr inside {7'h01, 7'h02, 7'h07, 7'h0e, 7'h20, 7'h2c, 7'h2d, 7'h2f, 7'h3a};
  // shadow copies of the few bits that steer timing-free relations
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_ff <= 1'b0;
      mute_ff <= 1'b0;
      adc_ff <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `ADDR_LEVEL_LOOP_GAIN_LIMITS) lvl_ff <= i_reg_wdata[8];
      if (i_reg_addr == `ADDR_INPUT_AMP_GAIN) mute_ff <= i_reg_wdata[6];
      if (i_reg_addr == `ADDR_POWER_MANAGE_TWO) adc_ff <= i_reg_wdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////
  rvalid_follows_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read gave no valid");
  rvalid_spurious_a: assert property (!i_reg_rd |=> !o_reg_rvalid)
    else $error("valid without read");
  unmapped_zero_a: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 9'h000)
    else $error("unmapped read not zero");
  neg_route_a: assert property (i_reg_wr && i_reg_addr == 7'h2c |-> ##2
    o_neg_mic_to_amp == $past(i_reg_wdata[1], 2)) else $error("neg mic switch wrong");
  boost_power_a: assert property (i_reg_wr && i_reg_addr == 7'h02 |-> ##2
    o_boost_enable == $past(i_reg_wdata[4], 2)) else $error("boost power wrong");
  bias_mode_a: assert property (i_reg_wr && i_reg_addr == 7'h3a |-> ##2
    o_bias_select[2] == $past(i_reg_wdata[4], 2)) else $error("bias mode wrong");
  loop_gain_a: assert property (lvl_ff |=>
    o_input_amp_gain_code == $past(i_level_loop_gain)) else $error("loop gain not used");
  mute_path_a: assert property (1'b1 |=> o_amp_to_mixer != $past(mute_ff))
    else $error("mute path wrong");
  aux_connect_a: assert property (o_aux_boost_connect == (o_aux_boost_gain != 3'h0))
    else $error("aux connect wrong");
  pos_connect_a: assert property (o_pos_mic_boost_connect == (o_pos_mic_boost_gain != 3'h0))
    else $error("pos connect wrong");
  off_quiet_a: assert property (!adc_ff [*3] |-> !o_sample_valid && o_sample == 24'h000000)
    else $error("chain active while off");
  word_spacing_a: assert property (o_sample_valid |=> !o_sample_valid [*8])
    else $error("words too close");
  // main scenarios reached
  cover property (o_sample_valid);
  cover property (i_reg_rd && !mapped);
  cover property (lvl_ff && o_input_amp_gain_code != 6'h00);
endmodule // recpath_chk

bind record_path_adc_filter_control recpath_chk recpath_chk_i (
  .i_mclk, .i_rstn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
  .o_reg_rvalid, .i_level_loop_gain, .o_neg_mic_to_amp, .o_input_amp_gain_code,
  .o_amp_to_mixer, .o_boost_enable, .o_aux_boost_connect, .o_aux_boost_gain,
  .o_pos_mic_boost_connect, .o_pos_mic_boost_gain, .o_bias_select, .o_sample,
  .o_sample_valid
);

/* recpath_defines.svh */
/*
  register map, field positions, reset values and filter constants
  of the record path. assumes inclusion by bare name only.
*/
`ifndef RECPATH_DEFINES_SVH
`define RECPATH_DEFINES_SVH
`define NUM_REGS 9
`define ADDR_POWER_MANAGE_ONE 7'h01
`define ADDR_POWER_MANAGE_TWO 7'h02
`define ADDR_SAMPLE_RATE_SELECT 7'h07
`define ADDR_ADC_FILTER_CONTROL 7'h0e
`define ADDR_LEVEL_LOOP_GAIN_LIMITS 7'h20
`define ADDR_INPUT_ROUTING_CONTROL 7'h2c
`define ADDR_INPUT_AMP_GAIN 7'h2d
`define ADDR_BOOST_MIXER_CONTROL 7'h2f
`define ADDR_BIAS_MODE_CONTROL 7'h3a
`define MASK_POWER_MANAGE_ONE 9'h010
`define MASK_POWER_MANAGE_TWO 9'h015
`define MASK_SAMPLE_RATE_SELECT 9'h00e
`define MASK_ADC_FILTER_CONTROL 9'h1f9
`define MASK_LEVEL_LOOP_GAIN_LIMITS 9'h13f
`define MASK_INPUT_ROUTING_CONTROL 9'h187
`define MASK_INPUT_AMP_GAIN 9'h0ff
`define MASK_BOOST_MIXER_CONTROL 9'h177
`define MASK_BIAS_MODE_CONTROL 9'h010
`define RST_LEVEL_LOOP_GAIN_LIMITS 9'h038
`define RST_DEFAULT 9'h000
`define BIT_BIAS_OUTPUT_ENABLE 4
`define BIT_CONVERTER_ENABLE 0
`define BIT_INPUT_AMP_ENABLE 2
`define BIT_BOOST_ENABLE 4
`define BIT_CONVERTER_POLARITY 0
`define BIT_OVERSAMPLE_SELECT 3
`define BIT_HIGHPASS_ENABLE 8
`define BIT_HIGHPASS_MODE 7
`define BIT_LEVEL_LOOP_ENABLE 8
`define BIT_POS_MIC_TO_AMP 0
`define BIT_NEG_MIC_TO_AMP 1
`define BIT_AUX_TO_AMP 2
`define BIT_INPUT_AMP_MUTE 6
`define BIT_INPUT_AMP_ZERO_CROSS 7
`define BIT_AMP_PATH_BOOST 8
`define BIT_BIAS_MODE_SELECT 4
`define RATE_48K 3'h0
`define RATE_32K 3'h1
`define RATE_24K 3'h2
`define RATE_16K 3'h3
`define RATE_12K 3'h4
`define AUDIO_COEF_48K 16'hffe0
`define AUDIO_COEF_32K 16'hffd0
`define AUDIO_COEF_24K 16'hffc0
`define AUDIO_COEF_16K 16'hffa1
`define AUDIO_COEF_12K 16'hff81
`define AUDIO_COEF_8K 16'hff41
`define APP_COEF_0 16'hef83
`define APP_COEF_1 16'heb7e
`define APP_COEF_2 16'he5a9
`define APP_COEF_3 16'hdf3a
`define APP_COEF_4 16'hd6fc
`define APP_COEF_5 16'hcb86
`define APP_COEF_6 16'hbe41
`define APP_COEF_7 16'hadf8
`define OSR_LOW_LAST 7'h3f
`define OSR_HIGH_LAST 7'h7f
`define OSR_LOW_SHIFT 5
`define OSR_HIGH_SHIFT 2
`define SAT_POS 27'sh07fffff
`define SAT_NEG 27'sh7800000
`endif

/* recpath_pkg.sv */
/*
  shared types and the sample saturation helper.
  assumes recpath_defines.svh is on the include path.
*/
`include "recpath_defines.svh"
package recpath_pkg;
  typedef logic signed [23:0] sample_t;
  typedef logic [8:0] reg_word_t;
  typedef enum {OSR_64, OSR_128} osr_t;
  // clamp a wide value into the signed sample range
  function automatic sample_t sat24(input logic signed [26:0] v);
    if (v > `SAT_POS) return 24'h7fffff;
    if (v < `SAT_NEG) return 24'h800000;
    return v[23:0];
  endfunction
endpackage

/* sample_if.sv */
/*
  decimated sample stream between decimator and filter chain.
  assumes one clock; valid is a one-cycle pulse per sample.
*/
`timescale 1ns/1ps
interface sample_if import recpath_pkg::*;;
  sample_t data;
  logic valid;
  modport src (output data, output valid);
  modport snk (input data, input valid);
endinterface

/* stream_partner.sv */
/*
  modulator source and serializer sink beside the record path.
  assumes words are strobed for one full cycle.
*/
`timescale 1ns/1ps
module stream_partner import recpath_pkg::*; (
  input wire logic i_mclk, // clock
  input wire logic i_run, // modulator running
  input wire logic i_slow, // strobe every other cycle
  input wire logic i_level, // bit value while running
  output logic o_mod_bit, // modulator bit
  output logic o_mod_valid, // bit strobe
  input wire sample_t i_sample, // word from chain
  input wire logic i_sample_valid, // word strobe
  output int o_count, // words taken
  output int o_gap // cycles between last two words
);
  logic phase = 1'b0;
  int since = 0;
  initial begin
    o_mod_bit = 1'b0;
    o_mod_valid = 1'b0;
    o_count = 0;
    o_gap = 0;
  end
  // source: idle bit toggles so a stale value never looks valid
  always @(posedge i_mclk) begin
    #1;
    phase = ~phase;
    o_mod_valid = i_run && (!i_slow || phase);
    o_mod_bit = o_mod_valid ? i_level : ~o_mod_bit;
  end
  // sink: taken mid-cycle, away from the launching edge
  always @(negedge i_mclk) begin
    since++;
    if (i_sample_valid) begin
      o_gap = since;
      since = 0;
      o_count++;
    end
  end
endmodule // stream_partner

/* test_record_path_adc_filter_control.sv */
/*
  self-checking bench for the record path.
  assumes the design, checker and partner compile first.
*/
`timescale 1ns/1ps
`include "recpath_defines.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_record_path_adc_filter_control import recpath_pkg::*;;
  localparam logic [6:0] AT [9] = '{7'h01, 7'h02, 7'h07, 7'h0e, 7'h20, 7'h2c, 7'h2d, 7'h2f, 7'h3a};
  localparam logic [8:0] MT [9] = '{9'h010, 9'h015, 9'h00e, 9'h1f9, 9'h13f, 9'h187, 9'h0ff,
                                   9'h177, 9'h010};
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_reg_wr, i_reg_rd, i_mod_bit, i_mod_valid, o_reg_rvalid;
  logic [6:0] i_reg_addr;
  logic [8:0] i_reg_wdata, o_reg_rdata;
  logic [5:0] i_level_loop_gain, o_input_amp_gain_code;
  logic o_neg_mic_to_amp, o_pos_mic_to_amp, o_aux_to_amp, o_input_amp_enable;
  logic o_input_amp_zero_cross, o_amp_to_mixer, o_boost_enable, o_aux_boost_connect;
  logic o_amp_path_boost, o_pos_mic_boost_connect, o_bias_output_enable, o_sample_valid;
  logic [2:0] o_aux_boost_gain, o_pos_mic_boost_gain, o_bias_select;
  sample_t o_sample, ref_s;
  logic run, slow, level;
  int rx_count, gap, held;
  int mismatches = 0;
  int tests_run = 0;
  always #5 i_mclk = ~i_mclk;
  record_path_adc_filter_control record_path_adc_filter_control_i (.*);
  stream_partner stream_partner_i (.i_mclk, .i_run(run), .i_slow(slow), .i_level(level),
    .o_mod_bit(i_mod_bit), .o_mod_valid(i_mod_valid), .i_sample(o_sample),
    .i_sample_valid(o_sample_valid), .o_count(rx_count), .o_gap(gap));
  ////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge i_mclk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    step();
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    step();
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] ex);
    step();
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    step();
    i_reg_rd = 1'b0;
    `CHK("rvalid", 1'b1, o_reg_rvalid)
    `CHK("rdata", ex, o_reg_rdata)
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // bounded wait for n more words
  task automatic wait_words(input int n);
    int start;
    int guard;
    start = rx_count;
    guard = 0;
    while (rx_count < start + n && guard < n * 400) begin
      step();
      guard++;
    end
    if (rx_count < start + n) begin
      mismatches++;
      $display("mismatch word wait expected %0d seen %0d", n, rx_count - start);
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {i_reg_wr, i_reg_rd, run, slow, level} = 5'h00;
    i_reg_addr = 7'h00;
    i_reg_wdata = 9'h000;
    i_level_loop_gain = 6'h2a;
    repeat (12) @(posedge i_mclk);
    #1 i_rstn = 1'b1;
    for (int k = 0; k < 9; k++) rd(AT[k], k == 4 ? 9'h038 : 9'h000);
    rd(7'h03, 9'h000);
    `CHK("amp to mixer", 1'b1, o_amp_to_mixer)
    $display("test reset done");
    for (int k = 0; k < 9; k++) wr(AT[k], 9'h1ff);
    for (int k = 0; k < 9; k++) rd(AT[k], MT[k]);
    `CHK("neg mic", 1'b1, o_neg_mic_to_amp)
    `CHK("pos mic", 1'b1, o_pos_mic_to_amp)
    `CHK("aux amp", 1'b1, o_aux_to_amp)
    `CHK("amp on", 1'b1, o_input_amp_enable)
    `CHK("zero cross", 1'b1, o_input_amp_zero_cross)
    `CHK("loop gain", 6'h2a, o_input_amp_gain_code)
    `CHK("muted", 1'b0, o_amp_to_mixer)
    `CHK("boost on", 1'b1, o_boost_enable)
    `CHK("bias on", 1'b1, o_bias_output_enable)
    wr(`ADDR_LEVEL_LOOP_GAIN_LIMITS, 9'h038);
    wr(`ADDR_INPUT_AMP_GAIN, 9'h015);
    wr(`ADDR_INPUT_ROUTING_CONTROL, 9'h002);
    wr(`ADDR_POWER_MANAGE_TWO, 9'h000);
    wr(`ADDR_POWER_MANAGE_ONE, 9'h000);
    step();
    `CHK("field gain", 6'h15, o_input_amp_gain_code)
    `CHK("neg only", 2'b10, {o_neg_mic_to_amp, o_pos_mic_to_amp})
    `CHK("aux off", 1'b0, o_aux_to_amp)
    `CHK("powers off", 3'h0, {o_input_amp_enable, o_boost_enable, o_bias_output_enable})
    `CHK("unmuted", 1'b1, o_amp_to_mixer)
    $display("test routing done");
    for (int c = 0; c < 8; c++) begin
      wr(`ADDR_BOOST_MIXER_CONTROL, {c[0], 1'b0, 3'(7 - c), 1'b0, c[2:0]});
      wr(`ADDR_BIAS_MODE_CONTROL, {4'h0, c[2], 4'h0});
      wr(`ADDR_INPUT_ROUTING_CONTROL, {c[1:0], 7'h00});
      step();
      `CHK("aux boost", {c != 0, c[2:0]}, {o_aux_boost_connect, o_aux_boost_gain})
      `CHK("pos boost", {c != 7, 3'(7 - c)}, {o_pos_mic_boost_connect, o_pos_mic_boost_gain})
      `CHK("path boost", c[0], o_amp_path_boost)
      `CHK("bias select", c[2:0], o_bias_select)
    end
    $display("test boost and bias done");
    // stream: wait until two settled words meet
    run = 1'b1;
    level = 1'b1;
    wr(`ADDR_ADC_FILTER_CONTROL, 9'h000);
    wr(`ADDR_POWER_MANAGE_TWO, 9'h001);
    wait_words(5);
    `CHK("plus full", 24'h7fffff, o_sample)
    wr(`ADDR_ADC_FILTER_CONTROL, 9'h001);
    wait_words(3);
    `CHK("inverted", 24'h800001, o_sample)
    wr(`ADDR_ADC_FILTER_CONTROL, 9'h000);
    level = 1'b0;
    wait_words(6);
    `CHK("minus full", 24'h800000, o_sample)
    wr(`ADDR_POWER_MANAGE_TWO, 9'h000);
    held = rx_count;
    repeat (300) step();
    `CHK("off words", held, rx_count)
    `CHK("off sample", 24'h000000, o_sample)
    slow = 1'b1;
    for (int os = 0; os < 2; os++) begin
      wr(`ADDR_POWER_MANAGE_TWO, 9'h000);
      wr(`ADDR_ADC_FILTER_CONTROL, {5'h00, os[0], 3'h0});
      wr(`ADDR_POWER_MANAGE_TWO, 9'h001);
      wait_words(3);
      `CHK("word gap", 128 << os, gap)
    end
    $display("test stream done");
    slow = 1'b0;
    level = 1'b1;
    // high-pass: audio mode first, then every application corner
    for (int m = 0; m < 9; m++) begin
      wr(`ADDR_POWER_MANAGE_TWO, 9'h000);
      wr(`ADDR_ADC_FILTER_CONTROL, m == 0 ? 9'h100 : {2'b11, 3'(m - 1), 4'h0});
      wr(`ADDR_POWER_MANAGE_TWO, 9'h001);
      wait_words(10);
      if (m == 0) begin
        ref_s = o_sample;
        `CHK("audio decays", 1'b1, ref_s < 24'sh7fffff)
      end else begin
        `CHK("corner above audio", 1'b1, o_sample < ref_s)
      end
    end
    $display("test highpass done");
    give_verdict();
  end
endmodule // test_record_path_adc_filter_control
